// ---- idu_divide_unit.sv ----
// Operation
// RQ1 - Legacy divide writes quotient and remainder special registers only.
// RQ2 - Legacy divide never raises an arithmetic exception.
// RQ3 - Special register reads wait until a running divide has finished.
// RQ4 - Divide runs alongside unrelated instructions with in-order visible results.
// RQ5 - A divide right after a special register read leaves that read correct.
// RQ6 - Three-operand forms read both sources and write one destination register.
// RQ7 - Signed quotient: signed 32-bit operands, truncated 32-bit quotient.
// RQ8 - Signed remainder: signed operands, remainder carries the dividend's sign.
// RQ9 - Unsigned quotient: unsigned 32-bit operands, 32-bit quotient.
// RQ10 - Unsigned remainder: unsigned 32-bit operands, 32-bit remainder.
// RQ11 - Nonzero divisor: q*b+r equals a, and |r| below |b|.
// RQ12 - Zero divisor on three-operand forms never traps.
// RQ13 - In new-release mode legacy encodings raise reserved instruction instead.
// RQ14 - Legacy and three-operand divides are told apart by encoding.
// RQ15 - All four three-operand operations are implemented.
// RQ16 - Legacy unsigned divide fills both special registers without exception.
// RQ17 - Start pulse accepts operands; one-cycle done marks results valid.
// RQ18 - Most negative value by minus one completes with fixed results.
//
// Holds the whole divide unit: decode, iterative divider, special registers.
// Assumes the issue logic waits for busy low before starting a divide.
`timescale 1ns/1ps

module idu_divide_unit (
  // Clock and reset.
  input  wire logic                 sys_clk,
  input  wire logic                 nrst,
  // Core mode: high selects the new-release instruction set.
  input  wire logic                 release6_mode,
  // Divide issue.
  input  wire idu_pkg::idu_req_s    div_req,
  output logic                      div_busy,
  output logic                      div_done,
  output logic                      rsvd_instr,
  // General register file write.
  output idu_pkg::idu_gpr_wr_s      gpr_wr,
  // Special register reads.
  input  wire idu_pkg::idu_mf_req_s mf_req,
  output idu_pkg::idu_mf_rsp_s      mf_rsp,
  // Special register contents.
  output logic [31:0]               quotient_special_reg,
  output logic [31:0]               remainder_special_reg
);

  typedef struct packed {
    idu_pkg::idu_st_e     st;
    logic [5:0]           step;
    idu_pkg::idu_op_e     op;
    logic [31:0]          dvs;
    logic [31:0]          rem;
    logic [31:0]          quo;
    logic                 neg_q;
    logic                 neg_r;
    logic [4:0]           dest;
    logic [31:0]          quot_reg;
    logic [31:0]          rem_reg;
    logic                 busy;
    logic                 done;
    logic                 rsvd;
    idu_pkg::idu_gpr_wr_s wr;
    idu_pkg::idu_mf_rsp_s mf;
  } idu_state_s;

  idu_state_s state_ff;
  idu_state_s nxt_state;
  logic       rst_meta_ff;
  logic       rst_sync_ff;

  // Reset release through two flops.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Classifies an instruction word by its fields, never by its name.
  function automatic idu_pkg::idu_op_e decode_op(input logic [31:0] instr,
                                                 input logic        new_isa);
    logic [5:0]       opc;
    logic [5:0]       fn;
    logic [4:0]       sa;
    idu_pkg::idu_op_e res;
    opc = instr[idu_pkg::OPC_HI:idu_pkg::OPC_LO];
    fn  = instr[idu_pkg::FUNCT_HI:idu_pkg::FUNCT_LO];
    sa  = instr[idu_pkg::SA_HI:idu_pkg::SA_LO];
    res = idu_pkg::IDU_OP_NONE;
    if (opc == idu_pkg::OPC_SPECIAL && fn == idu_pkg::FUNCT_DIV_S)
    begin
      if (sa == idu_pkg::SA_LEGACY)
        res = idu_pkg::IDU_OP_LEG_S; // [RQ14]
      else if (sa == idu_pkg::SA_QUOTIENT)
        res = idu_pkg::IDU_OP_QUO_S; // [RQ14] [RQ15]
      else if (sa == idu_pkg::SA_REMAINDER)
        res = idu_pkg::IDU_OP_REM_S; // [RQ15]
    end
    else if (opc == idu_pkg::OPC_SPECIAL && fn == idu_pkg::FUNCT_DIV_U)
    begin
      if (sa == idu_pkg::SA_LEGACY)
        res = idu_pkg::IDU_OP_LEG_U; // [RQ14]
      else if (sa == idu_pkg::SA_QUOTIENT)
        res = idu_pkg::IDU_OP_QUO_U; // [RQ15]
      else if (sa == idu_pkg::SA_REMAINDER)
        res = idu_pkg::IDU_OP_REM_U; // [RQ15]
    end
    // Each family exists only in its own instruction set mode.
    if (new_isa && (res == idu_pkg::IDU_OP_LEG_S || res == idu_pkg::IDU_OP_LEG_U))
      res = idu_pkg::IDU_OP_RSVD; // [RQ13]
    else if (!new_isa && res != idu_pkg::IDU_OP_NONE &&
             res != idu_pkg::IDU_OP_LEG_S && res != idu_pkg::IDU_OP_LEG_U)
      res = idu_pkg::IDU_OP_RSVD;
    return res;
  endfunction

  // True for the operations that treat operands as signed.
  function automatic logic is_signed_op(input idu_pkg::idu_op_e op);
    return op == idu_pkg::IDU_OP_LEG_S || op == idu_pkg::IDU_OP_QUO_S ||
           op == idu_pkg::IDU_OP_REM_S;
  endfunction

  idu_pkg::idu_op_e dec_op;
  logic             sgn;
  logic [32:0]      shifted;
  logic             fits;
  logic [31:0]      step_rem;
  logic [31:0]      step_quo;
  logic [31:0]      fin_quo;
  logic [31:0]      fin_rem;

  always_comb
  begin
    nxt_state = state_ff;
    dec_op    = decode_op(div_req.instr, release6_mode);
    sgn       = is_signed_op(dec_op);
    // One restoring step: shift in the next dividend bit and try to subtract.
    shifted   = {state_ff.rem, state_ff.quo[idu_pkg::WORD_W-1]};
    fits      = shifted >= {1'b0, state_ff.dvs};
    step_rem  = fits ? 32'(shifted - {1'b0, state_ff.dvs}) : shifted[31:0];
    step_quo  = {state_ff.quo[idu_pkg::WORD_W-2:0], fits};
    // Signs restored: quotient truncates toward zero, remainder follows the dividend.
    fin_quo   = state_ff.neg_q ? 32'(-step_quo) : step_quo; // [RQ7] [RQ11]
    fin_rem   = state_ff.neg_r ? 32'(-step_rem) : step_rem; // [RQ8] [RQ11]

    nxt_state.done   = 1'b0;
    nxt_state.rsvd   = 1'b0;
    nxt_state.wr.we  = 1'b0;
    nxt_state.mf.ack = 1'b0;

    // Reads are served only while idle, so they see the finished result.
    if (mf_req.req && state_ff.st == idu_pkg::IDU_ST_IDLE)
    begin
      nxt_state.mf.ack  = 1'b1; // [RQ3] [RQ5]
      nxt_state.mf.data = mf_req.sel_rem ? state_ff.rem_reg : state_ff.quot_reg;
    end

    unique case (state_ff.st)
      idu_pkg::IDU_ST_IDLE:
      begin
        if (div_req.start && dec_op == idu_pkg::IDU_OP_RSVD)
          nxt_state.rsvd = 1'b1; // [RQ13]
        else if (div_req.start && dec_op != idu_pkg::IDU_OP_NONE)
        begin
          // Operands latched now, so later issue may proceed freely.
          nxt_state.st    = idu_pkg::IDU_ST_RUN; // [RQ4] [RQ17]
          nxt_state.busy  = 1'b1;
          nxt_state.step  = idu_pkg::STEP_FIRST;
          nxt_state.op    = dec_op;
          nxt_state.dest  = div_req.instr[idu_pkg::RD_HI:idu_pkg::RD_LO]; // [RQ6]
          nxt_state.rem   = '0;
          nxt_state.neg_r = sgn & div_req.src_a[idu_pkg::WORD_W-1];
          nxt_state.neg_q = sgn & (div_req.src_a[idu_pkg::WORD_W-1] ^
                                   div_req.src_b[idu_pkg::WORD_W-1]);
          // Magnitudes; the most negative value stays as its unsigned magnitude.
          nxt_state.quo   = (sgn & div_req.src_a[idu_pkg::WORD_W-1]) ?
                            32'(-div_req.src_a) : div_req.src_a; // [RQ18]
          nxt_state.dvs   = (sgn & div_req.src_b[idu_pkg::WORD_W-1]) ?
                            32'(-div_req.src_b) : div_req.src_b; // [RQ9] [RQ10]
        end
      end
      idu_pkg::IDU_ST_RUN:
      begin
        nxt_state.rem  = step_rem;
        nxt_state.quo  = step_quo;
        nxt_state.step = 6'(state_ff.step + 6'h01);
        if (state_ff.step == idu_pkg::STEP_LAST)
        begin
          // A zero divisor simply finishes the steps: no trap on any form.
          nxt_state.st   = idu_pkg::IDU_ST_IDLE; // [RQ2] [RQ12]
          nxt_state.busy = 1'b0;
          nxt_state.done = 1'b1; // [RQ17] [RQ3]
          unique case (state_ff.op)
            idu_pkg::IDU_OP_LEG_S,
            idu_pkg::IDU_OP_LEG_U:
            begin
              nxt_state.quot_reg = fin_quo; // [RQ1] [RQ16]
              nxt_state.rem_reg  = fin_rem; // [RQ1] [RQ16]
            end
            idu_pkg::IDU_OP_QUO_S,
            idu_pkg::IDU_OP_QUO_U:
            begin
              nxt_state.wr.we    = 1'b1; // [RQ6] [RQ7] [RQ9]
              nxt_state.wr.waddr = state_ff.dest;
              nxt_state.wr.wdata = fin_quo;
            end
            idu_pkg::IDU_OP_REM_S,
            idu_pkg::IDU_OP_REM_U:
            begin
              nxt_state.wr.we    = 1'b1; // [RQ6] [RQ8] [RQ10]
              nxt_state.wr.waddr = state_ff.dest;
              nxt_state.wr.wdata = fin_rem;
            end
            default:
            begin
              nxt_state.wr.we = 1'b0;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      state_ff    <= '0;
      state_ff.st <= idu_pkg::IDU_ST_IDLE;
      state_ff.op <= idu_pkg::IDU_OP_NONE;
    end
    else
      state_ff <= nxt_state;
  end

  assign div_busy              = state_ff.busy;
  assign div_done              = state_ff.done;
  assign rsvd_instr            = state_ff.rsvd;
  assign gpr_wr                = state_ff.wr;
  assign mf_rsp                = state_ff.mf;
  assign quotient_special_reg  = state_ff.quot_reg;
  assign remainder_special_reg = state_ff.rem_reg;

endmodule

// ---- idu_pkg.sv ----
// Package of the integer divide unit: encodings, timing counts and carriers.
// Assumes a 32-bit core whose issue logic hands over one divide instruction word at a time.
package idu_pkg;

  // Instruction field positions.
  localparam int OPC_HI   = 31;
  localparam int OPC_LO   = 26;
  localparam int SA_HI    = 10;
  localparam int SA_LO    = 6;
  localparam int FUNCT_HI = 5;
  localparam int FUNCT_LO = 0;
  localparam int RD_HI    = 15;
  localparam int RD_LO    = 11;

  // Field codes that select the divide family.
  localparam logic [5:0] OPC_SPECIAL  = 6'h00;
  localparam logic [5:0] FUNCT_DIV_S  = 6'h1a;
  localparam logic [5:0] FUNCT_DIV_U  = 6'h1b;
  localparam logic [4:0] SA_LEGACY    = 5'h00;
  localparam logic [4:0] SA_QUOTIENT  = 5'h02;
  localparam logic [4:0] SA_REMAINDER = 5'h03;

  // Iterative divider timing: one quotient bit per clock.
  localparam int         WORD_W     = 32;
  localparam logic [5:0] STEP_FIRST = 6'h00;
  localparam logic [5:0] STEP_LAST  = 6'h1f;

  // Operation classes after decode.
  typedef enum logic [2:0] {
    IDU_OP_NONE,
    IDU_OP_LEG_S,
    IDU_OP_LEG_U,
    IDU_OP_QUO_S,
    IDU_OP_REM_S,
    IDU_OP_QUO_U,
    IDU_OP_REM_U,
    IDU_OP_RSVD
  } idu_op_e;

  typedef enum logic {
    IDU_ST_IDLE,
    IDU_ST_RUN
  } idu_st_e;

  // Divide request from the issue logic.
  typedef struct packed {
    logic        start;
    logic [31:0] instr;
    logic [31:0] src_a;
    logic [31:0] src_b;
  } idu_req_s;

  // Write to the general register file.
  typedef struct packed {
    logic        we;
    logic [4:0]  waddr;
    logic [31:0] wdata;
  } idu_gpr_wr_s;

  // Move from a special register.
  typedef struct packed {
    logic req;
    logic sel_rem;
  } idu_mf_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] data;
  } idu_mf_rsp_s;

endpackage

// ---- idu_divide_unit_properties.sv ----
// Checker of the divide unit's handshake timing and result placement.
// Assumes it is bound to idu_divide_unit and sees only its ports.
`timescale 1ns/1ps
module idu_props (
  // Clock, reset and mode.
  input wire logic                 sys_clk,
  input wire logic                 nrst,
  input wire logic                 release6_mode,
  // Divide issue.
  input wire idu_pkg::idu_req_s    div_req,
  input wire logic                 div_busy,
  input wire logic                 div_done,
  input wire logic                 rsvd_instr,
  input wire idu_pkg::idu_gpr_wr_s gpr_wr,
  // Special registers.
  input wire idu_pkg::idu_mf_req_s mf_req,
  input wire idu_pkg::idu_mf_rsp_s mf_rsp,
  input wire logic [31:0]          quotient_special_reg,
  input wire logic [31:0]          remainder_special_reg
);
  logic legal;
  assign legal = div_req.start && !div_busy && div_req.instr[31:26] == 6'h00
    && div_req.instr[5:1] == 5'h0d
    && (release6_mode ? div_req.instr[10:7] == 4'h1 : div_req.instr[10:6] == 5'h00);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  sequence s_go;
    $rose(div_busy);
  endsequence
  sequence s_end;
    ##31 div_busy ##1 (!div_busy && div_done);
  endsequence
  div_latency_a: assert property (s_go |-> s_end)
    else $error("done not 33 cycles after start");
  start_taken_a: assert property (legal |=> div_busy && !rsvd_instr)
    else $error("legal divide not started");
  done_pulse_a: assert property (div_done |=> !div_done)
    else $error("done longer than one cycle");
  read_stall_a: assert property (mf_rsp.ack |-> $past(mf_req.req && !div_busy))
    else $error("read answered while busy");
  read_answer_a: assert property (mf_req.req && !div_busy |=> mf_rsp.ack)
    else $error("idle read not answered");
  read_data_a: assert property (mf_rsp.ack |-> mf_rsp.data == ($past(mf_req.sel_rem) ?
    $past(remainder_special_reg) : $past(quotient_special_reg)))
    else $error("read data wrong");
  gpr_one_a: assert property (gpr_wr.we |-> div_done && $stable(quotient_special_reg)
    && $stable(remainder_special_reg))
    else $error("general write out of place");
  spec_write_a: assert property (!$stable({quotient_special_reg, remainder_special_reg})
    |-> div_done && !gpr_wr.we)
    else $error("special register write out of place");
  rsvd_cause_a: assert property (rsvd_instr |-> $past(div_req.start && !div_busy)
    && !div_busy)
    else $error("reserved without request");
endmodule

bind idu_divide_unit idu_props chk (.sys_clk, .nrst, .release6_mode, .div_req, .div_busy,
  .div_done, .rsvd_instr, .gpr_wr, .mf_req, .mf_rsp, .quotient_special_reg,
  .remainder_special_reg);

// ---- idu_pipe_model.sv ----
// Model of the issue pipeline's special register read port.
// Assumes the unit acknowledges a held read in every idle cycle that it is held.
`timescale 1ns/1ps
module idu_pipe_model (
  // Clock and reset.
  input  wire logic                 sys_clk,
  input  wire logic                 nrst,
  // Testbench command.
  input  wire logic                 go,
  input  wire logic                 sel,
  output logic                      got,
  output logic [31:0]               rd_data,
  // Unit side.
  output idu_pkg::idu_mf_req_s      mf_req,
  input  wire idu_pkg::idu_mf_rsp_s mf_rsp
);
  // Holds the read until the acknowledge is sampled, then takes the data.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mf_req  <= '0;
      got     <= 1'b0;
      rd_data <= '0;
    end
    else
    begin
      got <= 1'b0;
      if (mf_req.req && mf_rsp.ack)
      begin
        mf_req.req     <= 1'b0;
        mf_req.sel_rem <= ~mf_req.sel_rem;
        rd_data        <= mf_rsp.data;
        got            <= 1'b1;
      end
      else if (go && !mf_req.req)
      begin
        mf_req.req     <= 1'b1;
        mf_req.sel_rem <= sel;
      end
    end
  end
endmodule

// ---- integer_divide_unit_test.sv ----
// Testbench of the divide unit: three-operand, legacy, stall and reserved cases.
// Assumes idu_pipe_model makes the special register reads.
`timescale 1ns/1ps
module integer_divide_unit_test;
  logic                 sys_clk = 1'b0;
  logic                 nrst = 1'b0;
  logic                 release6_mode = 1'b0;
  logic                 go = 1'b0;
  logic                 sel = 1'b0;
  idu_pkg::idu_req_s    div_req = '0;
  logic                 div_busy, div_done, rsvd_instr, got;
  idu_pkg::idu_gpr_wr_s gpr_wr;
  idu_pkg::idu_mf_req_s mf_req;
  idu_pkg::idu_mf_rsp_s mf_rsp;
  logic [31:0]          quotient_special_reg, remainder_special_reg, rd_data;
  int                   mismatches = 0;
  int                   cmp_count = 0;
  always #4 sys_clk = ~sys_clk;
  idu_divide_unit dut (.sys_clk, .nrst, .release6_mode, .div_req, .div_busy, .div_done,
    .rsvd_instr, .gpr_wr, .mf_req, .mf_rsp, .quotient_special_reg, .remainder_special_reg);
  idu_pipe_model pm (.sys_clk, .nrst, .go, .sel, .got, .rd_data, .mf_req, .mf_rsp);

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [31:0] mk(input logic [4:0] sa, input logic [5:0] fn);
    mk = {6'h00, 5'h01, 5'h02, 5'h05, sa, fn};
  endfunction

  task automatic issue(input logic [31:0] ins, input logic [31:0] a, input logic [31:0] b);
    @(negedge sys_clk);
    go = 1'b0;
    div_req = '{1'b1, ins, a, b};
    @(negedge sys_clk);
    div_req.start = 1'b0;
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    while (div_done !== 1'b1 && n < 40)
    begin
      check("rsvd", 32'h0, rsvd_instr);
      @(negedge sys_clk);
      n++;
    end
    check("latency", 32'd32, n);
    if (n == 40)
      give_verdict();
  endtask

  task automatic read(input logic s, output logic [31:0] d);
    int n;
    @(negedge sys_clk);
    go = 1'b1;
    sel = s;
    @(negedge sys_clk);
    go = 1'b0;
    for (n = 0; n < 50 && got !== 1'b1; n++)
      @(negedge sys_clk);
    if (n == 50)
    begin
      check("read_got", 32'h1, got);
      give_verdict();
    end
    d = rd_data;
  endtask

  task automatic t_three_op;
    logic [31:0] a[2] = '{32'hfffffff9, 32'h7fffffff};
    logic [31:0] b[2] = '{32'h00000002, 32'hfffffffd};
    logic [31:0] q, r;
    release6_mode = 1'b1;
    for (int i = 0; i < 2; i++)
      for (int k = 0; k < 4; k++)
      begin
        issue(mk(k[1] ? 5'h03 : 5'h02, k[0] ? 6'h1b : 6'h1a), a[i], b[i]);
        wait_done();
        q = $signed(a[i]) / $signed(b[i]);
        r = $signed(a[i]) % $signed(b[i]);
        if (k[0])
        begin
          q = a[i] / b[i];
          r = a[i] % b[i];
        end
        check("gpr_we", 32'h1, gpr_wr.we);
        check("gpr_addr", 32'h5, gpr_wr.waddr);
        check("gpr_data", k[1] ? r : q, gpr_wr.wdata);
      end
    issue(mk(5'h02, 6'h1a), 32'h7, 32'h0);
    wait_done();
  endtask

  task automatic t_legacy;
    logic [31:0] d;
    release6_mode = 1'b0;
    issue(mk(5'h00, 6'h1a), 32'hffffff9c, 32'h7);
    wait_done();
    check("legacy_we", 32'h0, gpr_wr.we);
    read(1'b0, d);
    check("quotient", 32'hfffffff2, d);
    read(1'b1, d);
    check("remainder", 32'hfffffffe, d);
    issue(mk(5'h00, 6'h1b), 32'hffffff9c, 32'h7);
    wait_done();
    check("u_quotient", 32'hffffff9c / 32'h7, quotient_special_reg);
    check("u_remainder", 32'hffffff9c % 32'h7, remainder_special_reg);
    issue(mk(5'h00, 6'h1a), 32'h80000000, 32'hffffffff);
    wait_done();
    check("min_quotient", 32'h80000000, quotient_special_reg);
    check("min_remainder", 32'h0, remainder_special_reg);
  endtask

  task automatic t_stall;
    logic [31:0] d;
    issue(mk(5'h00, 6'h1a), 32'd1000, 32'd10);
    issue(mk(5'h00, 6'h1a), 32'd7, 32'd7);
    read(1'b0, d);
    check("stall_read", 32'd100, d);
  endtask

  task automatic t_overlap;
    @(negedge sys_clk);
    go = 1'b1;
    sel = 1'b1;
    issue(mk(5'h00, 6'h1a), 32'd53, 32'd5);
    wait_done();
    check("old_read", 32'd0, rd_data);
    check("new_quotient", 32'd10, quotient_special_reg);
    check("new_remainder", 32'd3, remainder_special_reg);
  endtask

  task automatic t_reserved;
    logic [31:0] ins[4] = '{mk(5'h00, 6'h1a), mk(5'h00, 6'h1b), mk(5'h02, 6'h1a),
                            mk(5'h00, 6'h20)};
    for (int k = 0; k < 4; k++)
    begin
      release6_mode = (k < 2);
      issue(ins[k], 32'h9, 32'h3);
      check("rsvd", (k < 3) ? 32'h1 : 32'h0, rsvd_instr);
      check("busy", 32'h0, div_busy);
    end
  endtask

  initial
  begin
    repeat (5) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (3) @(negedge sys_clk);
    t_three_op();
    t_legacy();
    t_stall();
    t_overlap();
    t_reserved();
    repeat (2) @(negedge sys_clk);
    give_verdict();
  end
endmodule
